/* core/t8cc_regs.svh */
// Purpose: register offsets, field positions and reset values of the 8-bit timer compare unit
// Assumes: plain register port, 8-bit data in the low bits
// Notes: definitions only
`ifndef T8CC_REGS_SVH
`define T8CC_REGS_SVH

// ==========================================================
// register offsets
`define T8CC_ADDR_W 4
`define T8CC_OFS_CTRL 4'h0
`define T8CC_OFS_COUNT 4'h1
`define T8CC_OFS_CMP 4'h2
`define T8CC_OFS_FLAGS 4'h3
`define T8CC_OFS_IRQEN 4'h4
`define T8CC_OFS_ASYNC 4'h5
`define T8CC_OFS_TICKDIV 4'h6

// ==========================================================
// control register fields
`define T8CC_CS_LSB 0
`define T8CC_CS_MSB 2
`define T8CC_WGM1_BIT 3
`define T8CC_COM_LSB 4
`define T8CC_COM_MSB 5
`define T8CC_WGM0_BIT 6
`define T8CC_FOC_BIT 7

// ==========================================================
// flag, enable and async select fields
`define T8CC_OVF_BIT 0
`define T8CC_OCF_BIT 1
`define T8CC_AS_BIT 3

// ==========================================================
// values
`define T8CC_MAX 8'hff
`define T8CC_BOTTOM 8'h00
`define T8CC_RST_BYTE 8'h00

`endif

/* core/t8cc_pkg.sv */
// Purpose: types of the 8-bit timer compare unit
// Assumes: nothing
// Notes: constants live in t8cc_regs.svh
package t8cc_pkg;

  typedef enum logic [1:0] {
    T8CC_WGM_NORMAL = 2'h0,
    T8CC_WGM_PWM_PC = 2'h1,
    T8CC_WGM_CTC = 2'h2,
    T8CC_WGM_PWM_FAST = 2'h3
  } t8cc_wgm_t;

  typedef enum logic [1:0] {
    T8CC_COM_NONE = 2'h0,
    T8CC_COM_TOGGLE = 2'h1,
    T8CC_COM_CLEAR = 2'h2,
    T8CC_COM_SET = 2'h3
  } t8cc_com_t;

  typedef enum logic [1:0] {
    T8CC_DIR_UP = 2'b01,
    T8CC_DIR_DOWN = 2'b10
  } t8cc_dir_t;

endpackage

/* core/t8cc_timer.sv */
// Purpose: counter and output-compare core of an 8-bit timer
// Assumes: one core clock; the async timer oscillator arrives as a synchronous tick enable
// Notes: clock select 1..7 divides the core clock by 2**(n-1) in place of the missing prescaler
`timescale 1ns/1ns
`include "t8cc_regs.svh"

// Overview of operation
// - each tick clears, increments or decrements the count as the mode decides
// - counting steps by exactly one; clear forces the count to zero
// - bottom indication is high whenever the count is zero
// - clock select zero gives no ticks; the counter stays stopped
// - the count register is readable and writable at any time
// - a cpu count write beats clear or count in the same cycle
// - two waveform mode bits in the control register choose the sequence
// - overflow flag set where the mode says, may request an interrupt
// - comparator flags equality of count and compare value every cycle
// - a match sets the compare flag one tick later
// - enabled flag requests an interrupt and clears when serviced
// - writing one clears the compare flag, zero leaves it
// - output derives from match, mode and output mode, with bottom in fast pwm
// - compare value double buffered in pwm modes only
// - buffered value moves to active compare at top or bottom
// - cpu compare access reaches buffer when buffered, else active register
// - force strobe in non-pwm modes acts on output without flag or clear
// - a count write blocks matches in the next tick, even stopped
// - compare output state survives mode changes
// - output mode bits take effect at once, not buffered
// - max is 255; top is max or compare value per mode
// - ticks from core clock, or from the oscillator tick when async select set
// - mode zero counts up, wraps at 255, overflow when count becomes zero
// - mode two clears on compare match so compare sets the top
module t8cc_timer import t8cc_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_osc_tick,
  input wire logic i_ovf_irq_ack,
  input wire logic i_cmp_irq_ack,
  output logic o_ovf_irq,
  output logic o_cmp_irq,
  output logic o_compare_output,
  output logic o_pin_override,
  output logic o_bottom,
  output logic o_top
);

  // ==========================================================
  // registers
  logic [2:0] clock_source_sel_r;
  t8cc_wgm_t waveform_mode_sel_r;
  t8cc_com_t compare_output_mode_r;
  logic async_clock_sel_r;
  logic [7:0] timer_count_r;
  logic [7:0] compare_value_r;
  logic [7:0] compare_buf_r;
  logic overflow_flag_r;
  logic compare_match_flag_r;
  logic [1:0] irq_en_r;
  logic compare_output_r;
  logic [7:0] div_cnt_r;
  t8cc_dir_t dir_r;
  logic block_r;
  logic match_pend_r;
  logic [7:0] rdata_r;

  // ==========================================================
  // decode
  logic wr_ctrl, wr_count, wr_cmp, wr_flags, wr_irqen, wr_async;
  assign wr_ctrl = i_wr && (i_addr == `T8CC_OFS_CTRL);
  assign wr_count = i_wr && (i_addr == `T8CC_OFS_COUNT);
  assign wr_cmp = i_wr && (i_addr == `T8CC_OFS_CMP);
  assign wr_flags = i_wr && (i_addr == `T8CC_OFS_FLAGS);
  assign wr_irqen = i_wr && (i_addr == `T8CC_OFS_IRQEN);
  assign wr_async = i_wr && (i_addr == `T8CC_OFS_ASYNC);

  logic pwm_mode;
  assign pwm_mode = waveform_mode_sel_r[0];

  // ==========================================================
  // tick generation
  // select zero stops the tick
  logic tick;
  logic div_hit;
  always_comb begin
    div_hit = 1'b1;
    if (clock_source_sel_r > 3'h1) begin
      div_hit = (div_cnt_r & ((8'h01 << (clock_source_sel_r - 3'h1)) - 8'h01)) == 8'h00;
    end
  end
  assign tick = (clock_source_sel_r != 3'h0) && (async_clock_sel_r ? i_osc_tick : div_hit);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      div_cnt_r <= 8'h00;
    end else if (clock_source_sel_r == 3'h0) begin
      div_cnt_r <= 8'h00;
    end else if (!async_clock_sel_r) begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // ==========================================================
  // top, bottom, match
  // top per mode
  logic [7:0] top_val;
  assign top_val = (waveform_mode_sel_r == T8CC_WGM_CTC) ? compare_value_r : `T8CC_MAX;
  assign o_bottom = (timer_count_r == `T8CC_BOTTOM);
  assign o_top = (timer_count_r == top_val);
  logic match;
  assign match = (timer_count_r == compare_value_r);
  logic match_ok;
  assign match_ok = match && !block_r;

  // ==========================================================
  // counter
  logic [7:0] count_nxt;
  t8cc_dir_t dir_nxt;
  logic ovf_evt;
  always_comb begin
    count_nxt = timer_count_r;
    dir_nxt = dir_r;
    ovf_evt = 1'b0;
    unique case (waveform_mode_sel_r)
      T8CC_WGM_NORMAL: begin
        count_nxt = timer_count_r + 8'h01;
        ovf_evt = (timer_count_r == `T8CC_MAX);
      end
      T8CC_WGM_CTC: begin
        if (match) begin
          count_nxt = `T8CC_BOTTOM;
        end else begin
          count_nxt = timer_count_r + 8'h01;
        end
        ovf_evt = (timer_count_r == `T8CC_MAX);
      end
      T8CC_WGM_PWM_FAST: begin
        count_nxt = timer_count_r + 8'h01;
        ovf_evt = (timer_count_r == `T8CC_MAX);
      end
      T8CC_WGM_PWM_PC: begin
        if (dir_r == T8CC_DIR_UP) begin
          if (timer_count_r == `T8CC_MAX) begin
            dir_nxt = T8CC_DIR_DOWN;
            count_nxt = timer_count_r - 8'h01;
          end else begin
            count_nxt = timer_count_r + 8'h01;
          end
        end else begin
          if (timer_count_r == `T8CC_BOTTOM) begin
            dir_nxt = T8CC_DIR_UP;
            count_nxt = timer_count_r + 8'h01;
            ovf_evt = 1'b1;
          end else begin
            count_nxt = timer_count_r - 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      timer_count_r <= `T8CC_RST_BYTE;
      dir_r <= T8CC_DIR_UP;
    end else if (wr_count) begin
      timer_count_r <= i_wdata;
    end else if (tick) begin
      timer_count_r <= count_nxt;
      dir_r <= dir_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      block_r <= 1'b0;
    end else if (wr_count) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ==========================================================
  // compare value and buffer
  // buffering only in pwm modes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      compare_buf_r <= `T8CC_RST_BYTE;
    end else if (wr_cmp) begin
      compare_buf_r <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      compare_value_r <= `T8CC_RST_BYTE;
    end else if (!pwm_mode) begin
      if (wr_cmp) begin
        compare_value_r <= i_wdata;
      end
    end else if (tick && (o_top || o_bottom)) begin
      compare_value_r <= compare_buf_r;
    end
  end

  // ==========================================================
  // flags
  // flag one tick after match
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      match_pend_r <= 1'b0;
    end else if (tick) begin
      match_pend_r <= match_ok;
    end
  end

  logic cmp_set, ovf_set;
  assign cmp_set = tick && match_pend_r;
  assign ovf_set = tick && ovf_evt && !wr_count;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      compare_match_flag_r <= 1'b0;
    end else if (cmp_set) begin
      compare_match_flag_r <= 1'b1;
    end else if ((wr_flags && i_wdata[`T8CC_OCF_BIT]) || i_cmp_irq_ack) begin
      compare_match_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      overflow_flag_r <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag_r <= 1'b1;
    end else if ((wr_flags && i_wdata[`T8CC_OVF_BIT]) || i_ovf_irq_ack) begin
      overflow_flag_r <= 1'b0;
    end
  end

  assign o_cmp_irq = compare_match_flag_r && irq_en_r[`T8CC_OCF_BIT];
  assign o_ovf_irq = overflow_flag_r && irq_en_r[`T8CC_OVF_BIT];

  // ==========================================================
  // control registers
  // output mode applies at once
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      clock_source_sel_r <= 3'h0;
      waveform_mode_sel_r <= T8CC_WGM_NORMAL;
      compare_output_mode_r <= T8CC_COM_NONE;
    end else if (wr_ctrl) begin
      clock_source_sel_r <= i_wdata[`T8CC_CS_MSB:`T8CC_CS_LSB];
      waveform_mode_sel_r <= t8cc_wgm_t'({i_wdata[`T8CC_WGM1_BIT], i_wdata[`T8CC_WGM0_BIT]});
      compare_output_mode_r <= t8cc_com_t'(i_wdata[`T8CC_COM_MSB:`T8CC_COM_LSB]);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_en_r <= 2'h0;
      async_clock_sel_r <= 1'b0;
    end else begin
      if (wr_irqen) begin
        irq_en_r <= i_wdata[1:0];
      end
      if (wr_async) begin
        async_clock_sel_r <= i_wdata[`T8CC_AS_BIT];
      end
    end
  end

  // ==========================================================
  // waveform output
  // force strobe acts only in non-pwm modes
  logic force_hit;
  assign force_hit = wr_ctrl && i_wdata[`T8CC_FOC_BIT] && !pwm_mode;
  logic out_nxt;
  always_comb begin
    out_nxt = compare_output_r;
    if (!pwm_mode) begin
      if (force_hit || (tick && match_ok)) begin
        unique case (wr_ctrl ? t8cc_com_t'(i_wdata[`T8CC_COM_MSB:`T8CC_COM_LSB]) : compare_output_mode_r)
          T8CC_COM_NONE: out_nxt = compare_output_r;
          T8CC_COM_TOGGLE: out_nxt = !compare_output_r;
          T8CC_COM_CLEAR: out_nxt = 1'b0;
          T8CC_COM_SET: out_nxt = 1'b1;
        endcase
      end
    end else if (tick) begin
      // pwm: set at bottom (fast pwm only), clear on match (non-inverting); com 3 inverts
      if (compare_output_mode_r[1]) begin
        if (match_ok) begin
          out_nxt = (compare_output_mode_r == T8CC_COM_SET);
        end else if (o_bottom && waveform_mode_sel_r == T8CC_WGM_PWM_FAST) begin
          out_nxt = (compare_output_mode_r == T8CC_COM_CLEAR);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      compare_output_r <= 1'b0;
    end else begin
      compare_output_r <= out_nxt;
    end
  end
  assign o_compare_output = compare_output_r;
  assign o_pin_override = (compare_output_mode_r != T8CC_COM_NONE);

  // ==========================================================
  // read port
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `T8CC_OFS_CTRL: rdata_r <= {1'b0, waveform_mode_sel_r[0], compare_output_mode_r,
                                    waveform_mode_sel_r[1], clock_source_sel_r};
        `T8CC_OFS_COUNT: rdata_r <= timer_count_r;
        `T8CC_OFS_CMP: rdata_r <= pwm_mode ? compare_buf_r : compare_value_r;
        `T8CC_OFS_FLAGS: rdata_r <= {6'h00, compare_match_flag_r, overflow_flag_r};
        `T8CC_OFS_IRQEN: rdata_r <= {6'h00, irq_en_r};
        `T8CC_OFS_ASYNC: rdata_r <= {4'h0, async_clock_sel_r, 3'h0};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign o_rdata = rdata_r;

  // ==========================================================
  // assertions
  a_stop_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (clock_source_sel_r == 3'h0 && !wr_count) |=> $stable(timer_count_r))
    else $error("count moved while stopped");
  a_write_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_count |=> timer_count_r == $past(i_wdata))
    else $error("count write lost");
  a_bottom_ind: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_bottom == (timer_count_r == 8'h00))
    else $error("bottom indication wrong");
  a_normal_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (tick && !wr_count && waveform_mode_sel_r == T8CC_WGM_NORMAL && !wr_ctrl)
      |=> timer_count_r == 8'($past(timer_count_r) + 8'h01))
    else $error("normal mode step wrong");
  a_ovf_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (tick && !wr_count && waveform_mode_sel_r == T8CC_WGM_NORMAL && timer_count_r == 8'hff)
      |=> overflow_flag_r && timer_count_r == 8'h00)
    else $error("overflow not set at wrap");
  a_ctc_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (tick && !wr_count && waveform_mode_sel_r == T8CC_WGM_CTC && match && !wr_ctrl)
      |=> timer_count_r == 8'h00)
    else $error("ctc did not clear");
  a_flag_late: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (tick && match_ok && !match_pend_r ##1 (!tick && !i_cmp_irq_ack && !wr_flags)) |-> !$rose(compare_match_flag_r))
    else $error("flag set in match tick");
  a_block_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_count |=> !match_ok)
    else $error("match not blocked");
  a_flag_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_flags && i_wdata[1] && !cmp_set) |=> !compare_match_flag_r)
    else $error("flag not cleared");
  a_irq_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_cmp_irq == (compare_match_flag_r && irq_en_r[1]))
    else $error("compare irq gating wrong");
  a_direct_cmp: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_cmp && !pwm_mode) |=> compare_value_r == $past(i_wdata))
    else $error("direct compare write lost");

  c_ctc_wrap: cover property (@(posedge i_core_clk) tick && waveform_mode_sel_r == T8CC_WGM_CTC && match);
  c_force: cover property (@(posedge i_core_clk) force_hit);
  c_pwm_load: cover property (@(posedge i_core_clk) tick && pwm_mode && o_bottom);
  c_ovf: cover property (@(posedge i_core_clk) ovf_set);

endmodule // t8cc_timer

/* testbench/t8cc_cpu_model.sv */
// Purpose: far-side model: oscillator tick source and interrupt service
// Assumes: one core clock; ticks are only sent on request
// Notes: the tick line stands low between requests so tick counts stay exact
`timescale 1ns/1ns
module t8cc_cpu_model (
  input wire logic i_core_clk,
  input wire logic i_service_en,
  input wire logic i_ovf_irq,
  input wire logic i_cmp_irq,
  output logic o_osc_tick,
  output logic o_ovf_ack,
  output logic o_cmp_ack
);
  // ==========================================
  // tick source
  initial begin
    o_osc_tick = 1'b0;
    o_ovf_ack = 1'b0;
    o_cmp_ack = 1'b0;
  end
  task automatic send_ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      o_osc_tick <= 1'b1;
      @(posedge i_core_clk);
      o_osc_tick <= 1'b0;
    end
    @(posedge i_core_clk);
    #1;
  endtask
  // ==========================================
  // interrupt service
  // one ack per request; held off while an ack is out so a slow flag is not acked twice
  always @(posedge i_core_clk) begin
    o_ovf_ack <= i_service_en && i_ovf_irq && !o_ovf_ack;
    o_cmp_ack <= i_service_en && i_cmp_irq && !o_cmp_ack;
  end
endmodule // t8cc_cpu_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the 8-bit timer compare unit
// Assumes: ticks come from the model's oscillator line except in the last test
// Notes: exact counts rely on ticks sent one at a time
`timescale 1ns/1ns
`include "t8cc_regs.svh"
module tb_top;
  localparam logic [3:0] a_ctl = `T8CC_OFS_CTRL;
  localparam logic [3:0] a_cnt = `T8CC_OFS_COUNT;
  localparam logic [3:0] a_cmp = `T8CC_OFS_CMP;
  localparam logic [3:0] a_flg = `T8CC_OFS_FLAGS;
  localparam logic [3:0] a_ien = `T8CC_OFS_IRQEN;
  localparam logic [3:0] a_asy = `T8CC_OFS_ASYNC;
  logic core_clk, rst_n, wr, rd, svc;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic osc_tick, ovf_ack, cmp_ack, ovf_irq, cmp_irq, cout, pov, bot, top;
  logic [7:0] fc [4] = '{8'ha1, 8'h91, 8'h91, 8'hb1};
  logic [7:0] fo [4] = '{8'h00, 8'h01, 8'h00, 8'h01};
  int miscompares = 0;
  int tests_run = 0;
  // ==========================================
  // design and far side
  t8cc_timer dut (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_osc_tick(osc_tick), .i_ovf_irq_ack(ovf_ack), .i_cmp_irq_ack(cmp_ack),
    .o_ovf_irq(ovf_irq), .o_cmp_irq(cmp_irq), .o_compare_output(cout), .o_pin_override(pov),
    .o_bottom(bot), .o_top(top));
  t8cc_cpu_model cpu (.i_core_clk(core_clk), .i_service_en(svc), .i_ovf_irq(ovf_irq), .i_cmp_irq(cmp_irq),
    .o_osc_tick(osc_tick), .o_ovf_ack(ovf_ack), .o_cmp_ack(cmp_ack));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================
  // bus tasks and checks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_reg(input string n, input logic [3:0] a, input logic [7:0] e);
    rd_reg(a, v);
    chk(n, v, e);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    miscompares++;
    print_verdict();
  end
  // ==========================================
  // tests
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    svc = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_reg("ctrl", a_ctl, 8'h00);
    chk_reg("count", a_cnt, 8'h00);
    chk_reg("compare", a_cmp, 8'h00);
    chk_reg("flags", a_flg, 8'h00);
    chk_reg("unmapped", 4'hf, 8'h00);
    chk("bottom", bot, 8'h01);
    chk("output", cout, 8'h00);
    wr_reg(a_asy, 8'h08);
    wr_reg(a_cnt, 8'h05);
    cpu.send_ticks(3);
    chk_reg("stopped count", a_cnt, 8'h05);
    wr_reg(a_ctl, 8'h01);
    fork
      wr_reg(a_cnt, 8'h20);
      cpu.send_ticks(1);
    join
    chk_reg("write beats tick", a_cnt, 8'h20);
    wr_reg(a_cmp, 8'h80);
    wr_reg(a_cnt, 8'hfd);
    cpu.send_ticks(2);
    chk("top at max", top, 8'h01);
    chk_reg("count up", a_cnt, 8'hff);
    cpu.send_ticks(1);
    chk("bottom", bot, 8'h01);
    chk_reg("wrap overflow", a_flg, 8'h01);
    wr_reg(a_ien, 8'h01);
    chk("ovf irq", ovf_irq, 8'h01);
    wr_reg(a_flg, 8'h00);
    chk_reg("write zero", a_flg, 8'h01);
    wr_reg(a_flg, 8'h01);
    chk_reg("write one", a_flg, 8'h00);
    wr_reg(a_cmp, 8'h10);
    wr_reg(a_cnt, 8'h0e);
    cpu.send_ticks(3);
    chk_reg("flag not yet", a_flg, 8'h00);
    cpu.send_ticks(1);
    chk_reg("flag next tick", a_flg, 8'h02);
    wr_reg(a_ien, 8'h02);
    chk("cmp irq", cmp_irq, 8'h01);
    @(posedge core_clk);
    svc <= 1'b1;
    repeat (4) @(posedge core_clk);
    svc <= 1'b0;
    #1;
    chk("serviced irq", cmp_irq, 8'h00);
    chk_reg("serviced flag", a_flg, 8'h00);
    // equal count and compare on purpose, against the usual software advice
    wr_reg(a_cnt, 8'h10);
    cpu.send_ticks(2);
    chk_reg("blocked match", a_flg, 8'h00);
    wr_reg(a_ctl, 8'h09);
    wr_reg(a_cmp, 8'h03);
    wr_reg(a_cnt, 8'h00);
    cpu.send_ticks(3);
    chk("top at compare", top, 8'h01);
    chk_reg("ctc at top", a_cnt, 8'h03);
    cpu.send_ticks(1);
    chk_reg("ctc clear", a_cnt, 8'h00);
    cpu.send_ticks(1);
    chk_reg("ctc match flag", a_flg, 8'h02);
    wr_reg(a_ctl, 8'h01);
    wr_reg(a_cmp, 8'h10);
    wr_reg(a_cnt, 8'h05);
    wr_reg(a_ctl, 8'h49);
    wr_reg(a_cmp, 8'h07);
    chk_reg("buffer read", a_cmp, 8'h07);
    wr_reg(a_flg, 8'h03);
    cpu.send_ticks(4);
    chk_reg("pwm count", a_cnt, 8'h09);
    chk_reg("buffer held", a_flg, 8'h00);
    wr_reg(a_cnt, 8'hfe);
    cpu.send_ticks(11);
    chk_reg("buffer copied", a_flg, 8'h03);
    wr_reg(a_ctl, 8'h01);
    wr_reg(a_flg, 8'h03);
    // output state is set up by force in normal mode first
    for (int i = 0; i < 4; i++) begin
      wr_reg(a_ctl, fc[i]);
      repeat (2) @(posedge core_clk);
      #1;
      chk("forced output", cout, fo[i]);
    end
    chk("override", pov, 8'h01);
    chk_reg("force no clear", a_cnt, 8'h09);
    chk_reg("force no flag", a_flg, 8'h00);
    wr_reg(a_ctl, 8'h49);
    chk("override off", pov, 8'h00);
    chk("kept output", cout, 8'h01);
    wr_reg(a_ctl, 8'hd9);
    repeat (2) @(posedge core_clk);
    #1;
    chk("pwm force", cout, 8'h01);
    // phase correct: turn at max, overflow at the bottom turnaround
    wr_reg(a_ctl, 8'h41);
    wr_reg(a_cnt, 8'hfe);
    cpu.send_ticks(2);
    chk_reg("pc down step", a_cnt, 8'hfe);
    wr_reg(a_cnt, 8'h02);
    cpu.send_ticks(3);
    chk_reg("pc turnaround", a_cnt, 8'h01);
    chk_reg("pc overflow", a_flg, 8'h01);
    wr_reg(a_asy, 8'h00);
    wr_reg(a_ctl, 8'h01);
    wr_reg(a_cnt, 8'h00);
    repeat (20) @(posedge core_clk);
    rd_reg(a_cnt, v);
    chk("core clock ticks", {7'h00, v > 8'h10}, 8'h01);
    print_verdict();
  end
endmodule // tb_top
